/* design/anfl_core.sv */
// Auto-negotiation control, next-page exchange and fast link-down
`timescale 1ns/100ps
module anfl_core
#(
    parameter int WIN_BITS = 14
)
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    // Management register port
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [4:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    output logic [15:0] REG_RDATA,
    // Crossover state and pulse pairs
    input wire logic MDIX_STATE,
    output logic PAIR_A_TX,
    output logic PAIR_B_TX,
    input wire logic PAIR_A_RX,
    input wire logic PAIR_B_RX,
    // Legacy partner detection from the receive path
    input wire logic LEGACY_100_SEEN,
    input wire logic LEGACY_10_SEEN,
    // Line condition inputs
    input wire logic RX_ERROR_EVT,
    input wire logic CODE_VIOL_EVT,
    input wire logic LOW_QUALITY_EVT,
    input wire logic ENERGY_LOSS,
    // Link results
    output logic LINK_UP,
    output logic LINK_DROP,
    output logic AN_BUSY,
    output logic AN_DONE,
    output logic SPEED_100,
    output logic [15:0] PARTNER_BASE_PAGE
);
    initial
    begin
        if (WIN_BITS < $clog2(anfl_pkg::SLOW_WINDOW_CYC) || WIN_BITS > 24)
            $error("WIN_BITS out of range");
    end

    typedef enum {ST_IDLE, ST_SEND, ST_WAIT_NP, ST_PD, ST_DONE} anfl_state_t;
    anfl_state_t state_q;

    logic [15:0] bmc_q, adv_q, npt_q, npr_q, lp_base_q, cr3_q;
    logic page_rx_q, pdf_q, lp_an_q, lp_np_q;
    logic an_en_live_q, npt_written_q, link_q, drop_q, speed_q;

    // Input synchronisers for outside-domain signals
    logic [1:0] s_a, s_b, s_100, s_10, s_rxe, s_cv, s_lq, s_el, s_mdix;
    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            s_a <= 2'h0; s_b <= 2'h0; s_100 <= 2'h0; s_10 <= 2'h0;
            s_rxe <= 2'h0; s_cv <= 2'h0; s_lq <= 2'h0; s_el <= 2'h0;
            s_mdix <= 2'h0;
        end
        else
        begin
            s_a <= {s_a[0], PAIR_A_RX};
            s_b <= {s_b[0], PAIR_B_RX};
            s_100 <= {s_100[0], LEGACY_100_SEEN};
            s_10 <= {s_10[0], LEGACY_10_SEEN};
            s_rxe <= {s_rxe[0], RX_ERROR_EVT};
            s_cv <= {s_cv[0], CODE_VIOL_EVT};
            s_lq <= {s_lq[0], LOW_QUALITY_EVT};
            s_el <= {s_el[0], ENERGY_LOSS};
            s_mdix <= {s_mdix[0], MDIX_STATE};
        end
    end

    // Listen on the pair chosen by crossover state
    logic rx_pulse, rx_prev_q, rx_edge;
    assign rx_pulse = s_mdix[1] ? s_a[1] : s_b[1];
    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
            rx_prev_q <= 1'b0;
        else
            rx_prev_q <= rx_pulse;
    end
    assign rx_edge = rx_pulse && !rx_prev_q;

    // Register writes and start events
    logic wr_bmc, wr_npt, rd_npr, restart_req, soft_reset, pwr_up;
    logic start_an, link_fail;
    assign wr_bmc = REG_WR && REG_ADDR == anfl_pkg::REG_BASIC_MODE_CONTROL;
    assign wr_npt = REG_WR && REG_ADDR == anfl_pkg::REG_NEXT_PAGE_TRANSMIT;
    assign rd_npr = REG_RD && REG_ADDR == anfl_pkg::REG_NEXT_PAGE_RECEIVED;
    assign restart_req = wr_bmc && REG_WDATA[anfl_pkg::BMC_RESTART_BIT];
    assign soft_reset = wr_bmc && REG_WDATA[anfl_pkg::BMC_RESET_BIT];
    assign pwr_up = wr_bmc && bmc_q[anfl_pkg::BMC_POWER_DOWN_BIT]
        && !REG_WDATA[anfl_pkg::BMC_POWER_DOWN_BIT];
    assign link_fail = drop_q && an_en_live_q;
    logic boot_q;
    assign start_an = boot_q || soft_reset || restart_req || pwr_up
        || link_fail;

    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
            boot_q <= 1'b1;
        else
            boot_q <= 1'b0;
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            bmc_q <= anfl_pkg::BMC_RESET_VALUE;
            adv_q <= anfl_pkg::ADV_RESET_VALUE;
            cr3_q <= anfl_pkg::ZERO16;
        end
        else if (soft_reset)
        begin
            bmc_q <= anfl_pkg::BMC_RESET_VALUE;
            adv_q <= anfl_pkg::ADV_RESET_VALUE;
            cr3_q <= anfl_pkg::ZERO16;
        end
        else if (REG_WR)
        begin
            if (wr_bmc)
            begin
                bmc_q <= REG_WDATA;
                bmc_q[anfl_pkg::BMC_RESTART_BIT] <= 1'b0;
            end
            if (REG_ADDR == anfl_pkg::REG_AN_ADVERTISEMENT)
                adv_q <= REG_WDATA;
            if (REG_ADDR == anfl_pkg::REG_CONTROL_THREE)
                cr3_q <= REG_WDATA;
        end
    end

    // Enable bit only takes effect at a restart
    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
            an_en_live_q <= 1'b1;
        else if (soft_reset)
            an_en_live_q <= anfl_pkg::BMC_RESET_VALUE[anfl_pkg::BMC_AN_ENABLE_BIT];
        else if (restart_req)
            an_en_live_q <= REG_WDATA[anfl_pkg::BMC_AN_ENABLE_BIT];
    end

    // Burst receiver: clock pulses alternate with data pulses
    logic [7:0] gap_q;
    logic [4:0] bit_cnt_q;
    logic [15:0] word_q;
    logic word_valid_q, expect_data_q;
    localparam logic [7:0] DATA_GAP = 8'h28;
    localparam logic [7:0] BURST_END = 8'hc8;
    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            gap_q <= 8'h00; bit_cnt_q <= 5'h00; word_q <= 16'h0000;
            word_valid_q <= 1'b0; expect_data_q <= 1'b0;
        end
        else
        begin
            word_valid_q <= 1'b0;
            if (rx_edge)
            begin
                gap_q <= 8'h00;
                if (expect_data_q && gap_q < DATA_GAP)
                begin
                    word_q <= {1'b1, word_q[15:1]};
                    expect_data_q <= 1'b0;
                    bit_cnt_q <= bit_cnt_q + 5'h01;
                end
                else
                    expect_data_q <= 1'b1;
            end
            else if (gap_q != 8'hff)
            begin
                gap_q <= gap_q + 8'h01;
                if (expect_data_q && gap_q == DATA_GAP)
                begin
                    word_q <= {1'b0, word_q[15:1]};
                    expect_data_q <= 1'b0;
                    bit_cnt_q <= bit_cnt_q + 5'h01;
                end
                if (gap_q == BURST_END)
                begin
                    word_valid_q <= bit_cnt_q == 5'(anfl_pkg::WORD_BITS);
                    bit_cnt_q <= 5'h00;
                end
            end
        end
    end

    // Transmit serialiser: clock pulse then data pulse per bit
    logic [15:0] tx_word_q;
    logic [5:0] tx_slot_q;
    logic [7:0] tx_tmr_q;
    logic tx_pulse;
    assign tx_pulse = tx_tmr_q < 8'h02 && tx_slot_q < 6'h20
        && (!tx_slot_q[0] || tx_word_q[tx_slot_q[4:1]]);
    assign PAIR_A_TX = !s_mdix[1] && tx_pulse && state_q == ST_SEND;
    assign PAIR_B_TX = s_mdix[1] && tx_pulse && state_q == ST_SEND;
    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            tx_slot_q <= 6'h00; tx_tmr_q <= 8'h00;
        end
        else if (state_q != ST_SEND)
        begin
            tx_slot_q <= 6'h00; tx_tmr_q <= 8'h00;
        end
        else if (tx_tmr_q == DATA_GAP)
        begin
            tx_tmr_q <= 8'h00;
            tx_slot_q <= tx_slot_q == 6'h3f ? 6'h00 : tx_slot_q + 6'h01;
        end
        else
            tx_tmr_q <= tx_tmr_q + 8'h01;
    end

    // Negotiation sequence with next pages and parallel detection
    logic np_mode;
    assign np_mode = adv_q[anfl_pkg::ADV_NEXT_PAGE_BIT];
    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            state_q <= ST_IDLE; tx_word_q <= 16'h0000; lp_base_q <= 16'h0000;
            npr_q <= 16'h0000; lp_an_q <= 1'b0; lp_np_q <= 1'b0; pdf_q <= 1'b0;
            speed_q <= 1'b0; page_rx_q <= 1'b0; npt_written_q <= 1'b0;
        end
        else
        begin
            if (REG_RD && REG_ADDR == anfl_pkg::REG_AN_EXPANSION)
                page_rx_q <= 1'b0;
            if (wr_npt)
                npt_written_q <= 1'b1;
            if (start_an)
            begin
                npt_written_q <= 1'b1;
                lp_an_q <= 1'b0;
                pdf_q <= 1'b0;
                state_q <= an_en_live_q || restart_req ? ST_SEND : ST_DONE;
                tx_word_q <= adv_q;
            end
            else
                case (state_q)
                    ST_SEND:
                    begin
                        if (word_valid_q)
                        begin
                            lp_an_q <= 1'b1;
                            page_rx_q <= 1'b1; // set wins over read clear
                            if (!lp_an_q)
                            begin
                                lp_base_q <= word_q;
                                lp_np_q <= word_q[anfl_pkg::PAGE_NEXT_BIT];
                            end
                            else if (npt_written_q || wr_npt)
                                npr_q <= word_q;
                            if (np_mode && (word_q[anfl_pkg::PAGE_NEXT_BIT]
                                || tx_word_q[anfl_pkg::PAGE_NEXT_BIT]))
                            begin
                                state_q <= ST_WAIT_NP;
                                npt_written_q <= wr_npt;
                            end
                            else
                            begin
                                state_q <= ST_DONE;
                                speed_q <= adv_q[anfl_pkg::ADV_100TX_BIT]
                                    && (lp_an_q
                                    ? lp_base_q[anfl_pkg::ADV_100TX_BIT]
                                    : word_q[anfl_pkg::ADV_100TX_BIT]);
                            end
                        end
                        else if (s_100[1] || s_10[1])
                            state_q <= ST_PD;
                    end
                    ST_WAIT_NP:
                        if (npt_written_q || wr_npt)
                        begin
                            tx_word_q <= wr_npt ? REG_WDATA : npt_q;
                            state_q <= ST_SEND;
                        end
                    ST_PD:
                    begin
                        speed_q <= s_100[1];
                        pdf_q <= s_100[1] && s_10[1];
                        state_q <= ST_DONE;
                    end
                    ST_DONE: state_q <= ST_DONE;
                    default: state_q <= ST_IDLE;
                endcase
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
            npt_q <= anfl_pkg::NPT_RESET_VALUE;
        else if (wr_npt)
            npt_q <= REG_WDATA;
    end

    // Link loss monitoring window and error counters
    logic [WIN_BITS-1:0] win_q;
    logic [5:0] rxe_cnt_q, cv_cnt_q, lq_cnt_q;
    logic fast_mode, win_end, trip;
    assign fast_mode = cr3_q[3:0] != 4'h0;
    // Compare with >= so a mode switch mid-window cannot skip the end
    assign win_end = win_q >= (fast_mode
        ? WIN_BITS'(anfl_pkg::FAST_WINDOW_CYC - 1)
        : WIN_BITS'(anfl_pkg::SLOW_WINDOW_CYC - 1));

    function automatic logic [5:0] bump(input logic [5:0] c, input logic e);
        bump = (e && c != 6'h3f) ? c + 6'h01 : c;
    endfunction : bump

    assign trip = fast_mode ? (
        (cr3_q[anfl_pkg::SEL_RX_ERROR]
            && rxe_cnt_q >= 6'(anfl_pkg::RX_ERR_LIMIT))
        || (cr3_q[anfl_pkg::SEL_CODE_VIOL]
            && cv_cnt_q >= 6'(anfl_pkg::CODE_VIOL_LIMIT))
        || (cr3_q[anfl_pkg::SEL_LOW_QUALITY]
            && lq_cnt_q >= 6'(anfl_pkg::LOW_QUAL_LIMIT))
        || (cr3_q[anfl_pkg::SEL_ENERGY_LOSS] && s_el[1]))
        : (win_end && s_el[1]);

    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            win_q <= '0; rxe_cnt_q <= 6'h00; cv_cnt_q <= 6'h00;
            lq_cnt_q <= 6'h00;
        end
        else if (win_end || !link_q)
        begin
            win_q <= '0; rxe_cnt_q <= 6'h00; cv_cnt_q <= 6'h00;
            lq_cnt_q <= 6'h00;
        end
        else
        begin
            win_q <= win_q + 1'b1;
            rxe_cnt_q <= bump(rxe_cnt_q, s_rxe[1]);
            cv_cnt_q <= bump(cv_cnt_q, s_cv[1]);
            lq_cnt_q <= bump(lq_cnt_q, s_lq[1]);
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            link_q <= 1'b0; drop_q <= 1'b0;
        end
        else
        begin
            drop_q <= link_q && trip;
            if (start_an || (link_q && trip))
                link_q <= 1'b0;
            else if (state_q == ST_DONE && !s_el[1])
                link_q <= 1'b1;
        end
    end

    // Register read mux
    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
            REG_RDATA <= 16'h0000;
        else if (REG_RD)
            case (REG_ADDR)
                anfl_pkg::REG_BASIC_MODE_CONTROL: REG_RDATA <= bmc_q;
                anfl_pkg::REG_AN_ADVERTISEMENT: REG_RDATA <= adv_q;
                anfl_pkg::REG_AN_EXPANSION:
                    REG_RDATA <= {11'h000, pdf_q, lp_np_q, np_mode,
                        page_rx_q, lp_an_q};
                anfl_pkg::REG_NEXT_PAGE_TRANSMIT: REG_RDATA <= npt_q;
                anfl_pkg::REG_NEXT_PAGE_RECEIVED: REG_RDATA <= npr_q;
                anfl_pkg::REG_CONTROL_THREE: REG_RDATA <= cr3_q;
                default: REG_RDATA <= 16'h0000;
            endcase
    end

    assign LINK_UP = link_q;
    assign LINK_DROP = drop_q;
    assign AN_BUSY = state_q == ST_SEND || state_q == ST_WAIT_NP;
    assign AN_DONE = state_q == ST_DONE;
    assign SPEED_100 = speed_q;
    assign PARTNER_BASE_PAGE = lp_base_q;
endmodule : anfl_core

/* design/anfl_pkg.sv */
// Constants for the auto-negotiation and fast link-down block
// Operation
// - Start negotiation on reset, restart, power-up
// - With enable set, power-up or link_fail starts
// - Enable change applies only at next restart
// - Send bursts on one pair, listen other
// - No partner negotiation: use parallel detection
// - Extract burst data bits into code word
// - Next pages from transmit, into receive register
// - After transmit write, new pages overwrite receive
// - Hold each next page until transmit written
// - Default window declares drops under 1 ms
// - Fast mode shortens window to 10 us
// - 32 receive errors per window drop link
// - 20 code violations per window drop link
// - 20 low-quality events per window drop link
// - Energy loss drops link at once
// - Criteria enabled singly or in combination
package anfl_pkg;
    localparam logic [4:0] REG_BASIC_MODE_CONTROL = 5'h00;
    localparam logic [4:0] REG_AN_ADVERTISEMENT = 5'h04;
    localparam logic [4:0] REG_AN_EXPANSION = 5'h06;
    localparam logic [4:0] REG_NEXT_PAGE_TRANSMIT = 5'h07;
    localparam logic [4:0] REG_NEXT_PAGE_RECEIVED = 5'h08;
    localparam logic [4:0] REG_CONTROL_THREE = 5'h0b;
    localparam int BMC_RESET_BIT = 15;
    localparam int BMC_AN_ENABLE_BIT = 12;
    localparam int BMC_POWER_DOWN_BIT = 11;
    localparam int BMC_RESTART_BIT = 9;
    localparam int ADV_NEXT_PAGE_BIT = 15;
    localparam int ADV_100TX_BIT = 7;
    localparam int PAGE_NEXT_BIT = 15;
    localparam int EXP_PAGE_RX_BIT = 1;
    localparam int EXP_LP_AN_ABLE_BIT = 0;
    localparam int EXP_NP_ABLE_BIT = 2;
    localparam int EXP_LP_NP_ABLE_BIT = 3;
    localparam int EXP_PDF_BIT = 4;
    localparam int SEL_RX_ERROR = 0;
    localparam int SEL_CODE_VIOL = 1;
    localparam int SEL_LOW_QUALITY = 2;
    localparam int SEL_ENERGY_LOSS = 3;
    localparam logic [15:0] BMC_RESET_VALUE = 16'h1000;
    localparam logic [15:0] ADV_RESET_VALUE = 16'h01e1;
    localparam logic [15:0] NPT_RESET_VALUE = 16'h2001;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam int CLK_FREQ_HZ = 10_000_000;
    localparam int FAST_WINDOW_US = 10;
    localparam int SLOW_WINDOW_US = 750;
    localparam int FAST_WINDOW_CYC = FAST_WINDOW_US * (CLK_FREQ_HZ / 1_000_000);
    localparam int SLOW_WINDOW_CYC = SLOW_WINDOW_US * (CLK_FREQ_HZ / 1_000_000);
    localparam int RX_ERR_LIMIT = 32;
    localparam int CODE_VIOL_LIMIT = 20;
    localparam int LOW_QUAL_LIMIT = 20;
    localparam int SLOW_ERR_LIMIT = 1;
    localparam int WORD_BITS = 16;
endpackage : anfl_pkg

/* test/anfl_core_checker.sv */
// Port assertions for the negotiation and link-down block
`timescale 1ns/100ps
module anfl_core_checker
#(
    parameter int WIN_BITS = 14
)
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    // Register port
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [4:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic [15:0] REG_RDATA,
    // Line side
    input wire logic MDIX_STATE,
    input wire logic PAIR_A_TX,
    input wire logic PAIR_B_TX,
    input wire logic ENERGY_LOSS,
    // Results
    input wire logic LINK_UP,
    input wire logic LINK_DROP,
    input wire logic AN_BUSY,
    input wire logic AN_DONE
);
    logic [3:0] sel_q;
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RESET_N);
    // Shadow of the criterion select field
    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
            sel_q <= 4'h0;
        else if (REG_WR && REG_ADDR == anfl_pkg::REG_BASIC_MODE_CONTROL
            && REG_WDATA[anfl_pkg::BMC_RESET_BIT])
            sel_q <= 4'h0;
        else if (REG_WR && REG_ADDR == anfl_pkg::REG_CONTROL_THREE)
            sel_q <= REG_WDATA[3:0];
    end
    sel_readback_a:
    assert property (REG_RD && !REG_WR && REG_ADDR == 5'h0b
        |=> REG_RDATA[3:0] == sel_q) else $error("select read back wrong");
    unmapped_zero_a:
    assert property (REG_RD && REG_ADDR == 5'h01 |=> REG_RDATA == 16'h0000)
        else $error("unmapped read not zero");
    rdata_hold_a:
    assert property (!REG_RD |=> $stable(REG_RDATA))
        else $error("read data moved without a read");
    drop_pulse_a:
    assert property (LINK_DROP |=> !LINK_DROP)
        else $error("link drop longer than one cycle");
    straight_quiet_a:
    assert property ((!MDIX_STATE)[*4] |-> !PAIR_B_TX)
        else $error("burst on listen pair while straight");
    cross_quiet_a:
    assert property (MDIX_STATE[*4] |-> !PAIR_A_TX)
        else $error("burst on listen pair while crossed");
    an_state_a:
    assert property (LINK_UP |-> AN_DONE && !AN_BUSY)
        else $error("link up before negotiation done");
    restart_busy_a:
    assert property (REG_WR && REG_ADDR == 5'h00 && REG_WDATA[9]
        && REG_WDATA[12] |-> ##[1:4] AN_BUSY) else $error("restart ignored");
    energy_drop_a:
    assert property (sel_q[3] && LINK_UP && $rose(ENERGY_LOSS)
        |-> ##[1:12] LINK_DROP) else $error("energy loss did not drop");
    cover property (LINK_DROP);
    cover property ($rose(AN_DONE));
    cover property ($rose(LINK_UP));
endmodule : anfl_core_checker

bind anfl_core anfl_core_checker #(.WIN_BITS(WIN_BITS)) u_chk
(
    .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .MDIX_STATE(MDIX_STATE), .PAIR_A_TX(PAIR_A_TX), .PAIR_B_TX(PAIR_B_TX),
    .ENERGY_LOSS(ENERGY_LOSS), .LINK_UP(LINK_UP), .LINK_DROP(LINK_DROP),
    .AN_BUSY(AN_BUSY), .AN_DONE(AN_DONE)
);

/* test/anfl_partner.sv */
// Remote link partner sending fast pulse bursts
`timescale 1ns/100ps
module anfl_partner
(
    // Clock and crossover state
    input wire logic clk,
    input wire logic mdix,
    // Pulses towards the device
    output logic rx_a,
    output logic rx_b
);
    logic pulse = 1'b0;
    // Device listens on B when straight, on A when crossed
    assign rx_a = mdix & pulse;
    assign rx_b = ~mdix & pulse;
    task automatic emit(input logic on);
        pulse = on;
        @(posedge clk) #1;
        pulse = 1'b0;
        repeat (39) @(posedge clk);
        #1;
    endtask : emit
    // Clock pulse, data pulse 40 cycles later for a one, LSB first
    task automatic send_word(input logic [15:0] w);
        for (int i = 0; i < 16; i++)
        begin
            emit(1'b1);
            emit(w[i]);
        end
        repeat (210) @(posedge clk);
        #1;
    endtask : send_word
endmodule : anfl_partner

/* test/anfl_core_bench.sv */
// Self-checking bench for the negotiation and link-down block
`timescale 1ns/100ps
module anfl_core_bench;
    logic CLK_SYS, RESET_N, REG_WR, REG_RD, MDIX_STATE;
    logic PAIR_A_TX, PAIR_B_TX, PAIR_A_RX, PAIR_B_RX;
    logic LEGACY_100_SEEN, LEGACY_10_SEEN, SPEED_100;
    logic LINK_UP, LINK_DROP, AN_BUSY, AN_DONE;
    logic [4:0] REG_ADDR;
    logic [15:0] REG_WDATA, REG_RDATA, PARTNER_BASE_PAGE, rd;
    logic [3:0] evt;
    logic [2:0] st;
    int n_fail = 0;
    int checks = 0;
    int drops = 0;
    int txp = 0;
    int d0;
    logic [4:0] ra [5] = '{5'h00, 5'h04, 5'h07, 5'h01, 5'h0b};
    logic [15:0] rv [5] = '{anfl_pkg::BMC_RESET_VALUE,
        anfl_pkg::ADV_RESET_VALUE, anfl_pkg::NPT_RESET_VALUE, 16'h0, 16'h0};
    logic [3:0] fm [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hf};
    int fe [5] = '{0, 1, 2, 3, 1};
    int fb [5] = '{31, 19, 19, 0, 19};
    int ft [5] = '{70, 46, 46, 20, 46};
    assign st = {LINK_DROP, LINK_UP, AN_DONE};
    anfl_core #(.WIN_BITS(14)) dut
    (
        .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .REG_WR(REG_WR),
        .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_RDATA(REG_RDATA), .MDIX_STATE(MDIX_STATE),
        .PAIR_A_TX(PAIR_A_TX), .PAIR_B_TX(PAIR_B_TX),
        .PAIR_A_RX(PAIR_A_RX), .PAIR_B_RX(PAIR_B_RX),
        .LEGACY_100_SEEN(LEGACY_100_SEEN), .LEGACY_10_SEEN(LEGACY_10_SEEN),
        .RX_ERROR_EVT(evt[0]), .CODE_VIOL_EVT(evt[1]),
        .LOW_QUALITY_EVT(evt[2]), .ENERGY_LOSS(evt[3]),
        .LINK_UP(LINK_UP), .LINK_DROP(LINK_DROP), .AN_BUSY(AN_BUSY),
        .AN_DONE(AN_DONE), .SPEED_100(SPEED_100),
        .PARTNER_BASE_PAGE(PARTNER_BASE_PAGE)
    );
    anfl_partner partner
    (
        .clk(CLK_SYS), .mdix(MDIX_STATE), .rx_a(PAIR_A_RX), .rx_b(PAIR_B_RX)
    );
    initial
    begin
        CLK_SYS = 1'b0;
        forever #50 CLK_SYS = ~CLK_SYS;
    end
    always @(posedge CLK_SYS)
    begin
        if (LINK_DROP === 1'b1)
            drops <= drops + 1;
        if ((PAIR_A_TX | PAIR_B_TX) === 1'b1)
            txp <= txp + 1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge CLK_SYS);
        #1;
    endtask : tick
    task automatic close_out;
        $display("Checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    task automatic check(input string nm, input logic [15:0] seen, exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        {REG_WR, REG_ADDR, REG_WDATA} = {1'b1, a, d};
        tick(1);
        REG_WR = 1'b0;
        tick(1);
    endtask : wr
    task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
        {REG_RD, REG_ADDR} = {1'b1, a};
        tick(1);
        REG_RD = 1'b0;
        d = REG_RDATA;
        tick(1);
    endtask : rd_reg
    // Bounded wait for done, link up or link drop
    task automatic wait_hi(input int k, input int lim);
        int i;
        i = 0;
        while (st[k] !== 1'b1 && i < lim)
        begin
            tick(1);
            i++;
        end
        check("status wait", 16'(i < lim), 16'h0001);
        if (i >= lim)
            close_out();
    endtask : wait_hi
    task automatic pulse(input int e, input int n);
        if (n > 0)
        begin
            evt[e] = 1'b1;
            tick(n);
            evt[e] = 1'b0;
        end
    endtask : pulse
    task automatic relink;
        wr(5'h00, 16'h1200);
        tick(5);
        wait_hi(1, 20000);
    endtask : relink
    initial
    begin
        RESET_N = 1'b0;
        {REG_WR, REG_RD, MDIX_STATE, LEGACY_100_SEEN, LEGACY_10_SEEN} = '0;
        REG_ADDR = 5'h00;
        REG_WDATA = 16'h0000;
        evt = 4'h0;
        tick(5);
        RESET_N = 1'b1;
        tick(2);
        for (int i = 0; i < 5; i++)
        begin
            rd_reg(ra[i], rd);
            check("reset value", rd & (i == 4 ? 16'hf : 16'hffff), rv[i]);
        end
        wr(5'h08, 16'hffff);
        rd_reg(5'h08, rd);
        check("received page write", rd, 16'h0000);
        $display("Test registers done");
        repeat (3) partner.send_word(16'h0181);
        check("partner base page", PARTNER_BASE_PAGE, 16'h0181);
        rd_reg(5'h06, rd);
        check("page flag set", rd & 16'h0003, 16'h0003);
        rd_reg(5'h06, rd);
        check("page flag cleared", rd & 16'h0002, 16'h0000);
        $display("Test base page done");
        MDIX_STATE = 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            LEGACY_100_SEEN = (k == 0);
            LEGACY_10_SEEN = (k == 1);
            wr(5'h00, 16'h1200);
            tick(5);
            wait_hi(0, 20000);
            check("detected speed", 16'(SPEED_100), 16'(k == 0));
        end
        wait_hi(1, 20000);
        wr(5'h00, 16'h0000);
        tick(50);
        check("enable change", 16'({LINK_UP, AN_BUSY}), 16'h0002);
        $display("Test parallel detection done");
        {LEGACY_100_SEEN, LEGACY_10_SEEN} = 2'b10;
        for (int s = 0; s < 5; s++)
        begin
            relink();
            wr(5'h0b, 16'(fm[s]));
            d0 = drops;
            repeat (2)
            begin
                pulse(fe[s], fb[s]);
                tick(120);
            end
            check("drop below limit", 16'(drops - d0), 16'h0000);
            pulse(fe[s], ft[s]);
            tick(10);
            check("at limit", 16'(drops > d0), 16'h1);
        end
        $display("Test fast link-down done");
        relink();
        wr(5'h0b, 16'h0000);
        evt[3] = 1'b1;
        wait_hi(2, 10000);
        evt[3] = 1'b0;
        $display("Test default window done");
        {LEGACY_100_SEEN, LEGACY_10_SEEN} = 2'b00;
        wr(5'h04, 16'h81e1);
        wr(5'h00, 16'h1200);
        partner.send_word(16'h8181);
        rd_reg(5'h06, rd);
        check("next page flags", rd & 16'h000e, 16'h000e);
        d0 = txp;
        tick(100);
        check("held next page", 16'(txp - d0), 16'h0000);
        rd_reg(5'h08, rd);
        wr(5'h07, 16'ha003);
        tick(100);
        check("sent next page", 16'(txp > d0), 16'h0001);
        partner.send_word(16'ha005);
        rd_reg(5'h06, rd);
        check("page flag again", rd & 16'h0002, 16'h0002);
        rd_reg(5'h08, rd);
        check("received next page", rd, 16'ha005);
        wr(5'h07, 16'h2001);
        partner.send_word(16'h2006);
        rd_reg(5'h08, rd);
        check("last next page", rd, 16'h2006);
        check("speed after pages", 16'({AN_DONE, SPEED_100}), 16'h0003);
        $display("Test next pages done");
        close_out();
    end
endmodule : anfl_core_bench
